// File: hw/ledrp_defs.svh
`ifndef LEDRP_DEFS_SVH
`define LEDRP_DEFS_SVH

// Register file
`define LEDRP_NUM_REGS 13
`define LEDRP_REG_MODE_A 4'h0
`define LEDRP_REG_MODE_B 4'h1
`define LEDRP_REG_LED0 4'h2
`define LEDRP_REG_LED1 4'h3
`define LEDRP_REG_LED2 4'h4
`define LEDRP_REG_LED3 4'h5
`define LEDRP_REG_GRP_DUTY 4'h6
`define LEDRP_REG_GRP_PERIOD 4'h7
`define LEDRP_REG_OUT_SEL 4'h8
`define LEDRP_REG_GCALL1 4'h9
`define LEDRP_REG_GCALL2 4'hA
`define LEDRP_REG_GCALL3 4'hB
`define LEDRP_REG_BCAST 4'hC
`define LEDRP_PTR_LAST 4'hC

// Control byte fields
`define LEDRP_CTRL_OPT_MSB 7
`define LEDRP_CTRL_OPT_LSB 5
`define LEDRP_CTRL_UNUSED_BIT 4
`define LEDRP_CTRL_PTR_MSB 3
`define LEDRP_CTRL_RESET 8'h80

// Increment options and wrap bounds
`define LEDRP_OPT_NONE 3'h0
`define LEDRP_OPT_ALL 3'h4
`define LEDRP_OPT_BRIGHT 3'h5
`define LEDRP_OPT_GROUP 3'h6
`define LEDRP_OPT_BR_GRP 3'h7
`define LEDRP_ALL_FIRST 4'h0
`define LEDRP_BRIGHT_FIRST 4'h2
`define LEDRP_BRIGHT_LAST 4'h5
`define LEDRP_GROUP_FIRST 4'h6
`define LEDRP_GROUP_LAST 4'h7

// First mode register fields and register write masks
`define LEDRP_MA_LOW_POWER_BIT 4
`define LEDRP_MA_GCALL1_BIT 3
`define LEDRP_MA_GCALL2_BIT 2
`define LEDRP_MA_GCALL3_BIT 1
`define LEDRP_MA_BCAST_BIT 0
`define LEDRP_MODE_A_WR_MASK 8'h1F
`define LEDRP_MODE_B_WR_MASK 8'h3F
`define LEDRP_FULL_WR_MASK 8'hFF

// Reset values
`define LEDRP_MODE_A_RESET 8'h11
`define LEDRP_MODE_B_RESET 8'h05
`define LEDRP_LED_RESET 8'h00
`define LEDRP_GRP_DUTY_RESET 8'hFF
`define LEDRP_GRP_PERIOD_RESET 8'h00
`define LEDRP_OUT_SEL_RESET 8'h00
`define LEDRP_GCALL1_RESET 8'hE2
`define LEDRP_GCALL2_RESET 8'hE4
`define LEDRP_GCALL3_RESET 8'hE8
`define LEDRP_BCAST_RESET 8'hE0

// Bus address and timing
`define LEDRP_SLAVE_ADDR_DEF 7'h2A
`define LEDRP_CLK_MHZ 100
`define LEDRP_WAKE_TIME_US 500
`define LEDRP_WAKE_CYCLES (`LEDRP_WAKE_TIME_US * `LEDRP_CLK_MHZ)

`endif

// File: hw/ledrp_pkg.sv
package ledrp_pkg;
   typedef enum logic [3:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ACK_ADDR,
      ST_CTRL,
      ST_ACK_CTRL,
      ST_WR,
      ST_ACK_WR,
      ST_RD,
      ST_ACK_RD
   } ledrp_state_e;

   typedef logic [3:0] ledrp_ptr_t;
   typedef logic [2:0] ledrp_opt_t;
   typedef logic [7:0] ledrp_byte_t;
endpackage

// File: hw/ledrp_sync.sv
module ledrp_sync #(
   parameter int WIDTH = 2
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_r;

   // Idle bus level is high, so both stages reset high
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '1;
         sync_o <= '1;
      end else begin
         meta_r <= async_i;
         sync_o <= meta_r;
      end
   end
endmodule

// File: hw/ledrp_ptr.sv
`include "ledrp_defs.svh"

module ledrp_ptr (
   input wire ledrp_pkg::ledrp_ptr_t ptr_i,
   input wire ledrp_pkg::ledrp_opt_t option_i,
   output ledrp_pkg::ledrp_ptr_t ptr_nxt
);
   // Step upward, but fold into the option's window at its last register
   function automatic ledrp_pkg::ledrp_ptr_t step(input ledrp_pkg::ledrp_ptr_t p,
                                                  input ledrp_pkg::ledrp_ptr_t last,
                                                  input ledrp_pkg::ledrp_ptr_t first);
      if (p == last) begin
         step = first;
      end else if (p >= `LEDRP_PTR_LAST) begin
         step = `LEDRP_ALL_FIRST;
      end else begin
         step = p + 4'h1;
      end
   endfunction

   always_comb begin
      case (option_i)
         `LEDRP_OPT_ALL: begin
            ptr_nxt = step(ptr_i, `LEDRP_PTR_LAST, `LEDRP_ALL_FIRST);
         end
         `LEDRP_OPT_BRIGHT: begin
            ptr_nxt = step(ptr_i, `LEDRP_BRIGHT_LAST, `LEDRP_BRIGHT_FIRST);
         end
         `LEDRP_OPT_GROUP: begin
            ptr_nxt = step(ptr_i, `LEDRP_GROUP_LAST, `LEDRP_GROUP_FIRST);
         end
         `LEDRP_OPT_BR_GRP: begin
            ptr_nxt = step(ptr_i, `LEDRP_GROUP_LAST, `LEDRP_BRIGHT_FIRST);
         end
         default: begin
            // Option 000 and the reserved codes leave the pointer alone
            ptr_nxt = ptr_i;
         end
      endcase
   end
endmodule

// File: hw/ledrp_top.sv
`include "ledrp_defs.svh"

// Summary of operation
// - First byte after a write address acknowledge is control
// - Low nibble pointer, top three bits option
// - Top option bit set advances pointer per byte
// - Option zero keeps pointer fixed
// - Option 100 wraps 1100 to 0000
// - Option 101 wraps 0101 to 0010
// - Option 110 wraps 0111 to 0110
// - Option 111 wraps 0111 to 0010
// - Increment changes only the pointer bits
// - Control pointer selects first register accessed
// - Out-of-window start counts up through zero
// - Pointers above 1100 are not acknowledged
// - Thirteen registers decoded at 00h to 0Ch
// - Mode bits 7:5 mirror option, read-only
// - Mode bit 4 selects low power
// - Mode bits 3:1 enable group-call addresses
// - Mode bit 0 enables broadcast address
// - Address byte bit zero selects direction
module ledrp_top #(
   parameter logic [6:0] SLAVE_ADDR = `LEDRP_SLAVE_ADDR_DEF,
   parameter int WAKE_CYCLES = `LEDRP_WAKE_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   output logic low_power_o,
   output logic osc_ready_o,
   output logic [7:0] mode_config_b_o,
   output logic [7:0] led0_brightness_o,
   output logic [7:0] led1_brightness_o,
   output logic [7:0] led2_brightness_o,
   output logic [7:0] led3_brightness_o,
   output logic [7:0] group_duty_o,
   output logic [7:0] group_period_o,
   output logic [7:0] led_output_select_o,
   output logic [3:0] register_pointer_o,
   output logic [2:0] increment_option_o
);
   localparam int WAKE_W = $clog2(WAKE_CYCLES + 1);
   localparam logic [WAKE_W-1:0] WAKE_LAST = WAKE_W'(WAKE_CYCLES);

   logic scl_s;
   logic sda_s;
   logic scl_d_r;
   logic sda_d_r;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;

   ledrp_pkg::ledrp_state_e state_r;
   logic [3:0] bit_cnt_r;
   ledrp_pkg::ledrp_byte_t shift_r;
   logic read_r;
   logic nack_r;
   ledrp_pkg::ledrp_byte_t ctrl_r;
   ledrp_pkg::ledrp_byte_t regs_r [`LEDRP_NUM_REGS];
   ledrp_pkg::ledrp_ptr_t ptr;
   ledrp_pkg::ledrp_ptr_t ptr_nxt;
   ledrp_pkg::ledrp_byte_t rd_data;
   logic [WAKE_W-1:0] wake_cnt_r;
   logic osc_ready_r;

   logic receiving;
   logic byte_end;
   logic addr_hit;
   logic addr_done;
   logic ctrl_done;
   logic ctrl_ok;
   logic wr_done;
   logic rd_done;
   logic rd_first;
   logic rd_next;
   logic rd_load;
   logic ack_end;

   function automatic ledrp_pkg::ledrp_byte_t reg_reset(input int idx);
      case (idx)
         0: reg_reset = `LEDRP_MODE_A_RESET;
         1: reg_reset = `LEDRP_MODE_B_RESET;
         6: reg_reset = `LEDRP_GRP_DUTY_RESET;
         7: reg_reset = `LEDRP_GRP_PERIOD_RESET;
         8: reg_reset = `LEDRP_OUT_SEL_RESET;
         9: reg_reset = `LEDRP_GCALL1_RESET;
         10: reg_reset = `LEDRP_GCALL2_RESET;
         11: reg_reset = `LEDRP_GCALL3_RESET;
         12: reg_reset = `LEDRP_BCAST_RESET;
         default: reg_reset = `LEDRP_LED_RESET;
      endcase
   endfunction

   // Bits outside the mask keep their stored value on a write
   function automatic ledrp_pkg::ledrp_byte_t wr_mask(input ledrp_pkg::ledrp_ptr_t idx);
      case (idx)
         `LEDRP_REG_MODE_A: wr_mask = `LEDRP_MODE_A_WR_MASK;
         `LEDRP_REG_MODE_B: wr_mask = `LEDRP_MODE_B_WR_MASK;
         default: wr_mask = `LEDRP_FULL_WR_MASK;
      endcase
   endfunction

   ledrp_sync #(
      .WIDTH(2)
   ) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .async_i({scl_i, sda_i}),
      .sync_o({scl_s, sda_s})
   );

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
      end
   end

   assign scl_rise = scl_s & ~scl_d_r;
   assign scl_fall = ~scl_s & scl_d_r;
   assign bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
   assign bus_stop = scl_s & scl_d_r & ~sda_d_r & sda_s;

   assign ptr = ctrl_r[`LEDRP_CTRL_PTR_MSB:0];

   ledrp_ptr u_ptr (
      .ptr_i(ptr),
      .option_i(ctrl_r[`LEDRP_CTRL_OPT_MSB:`LEDRP_CTRL_OPT_LSB]),
      .ptr_nxt(ptr_nxt)
   );

   // Own address, plus the enabled broadcast and group-call addresses
   always_comb begin
      addr_hit = (shift_r[7:1] == SLAVE_ADDR);
      if (regs_r[`LEDRP_REG_MODE_A][`LEDRP_MA_BCAST_BIT] &&
          shift_r[7:1] == regs_r[`LEDRP_REG_BCAST][7:1]) begin
         addr_hit = 1'b1;
      end
      if (regs_r[`LEDRP_REG_MODE_A][`LEDRP_MA_GCALL1_BIT] &&
          shift_r[7:1] == regs_r[`LEDRP_REG_GCALL1][7:1]) begin
         addr_hit = 1'b1;
      end
      if (regs_r[`LEDRP_REG_MODE_A][`LEDRP_MA_GCALL2_BIT] &&
          shift_r[7:1] == regs_r[`LEDRP_REG_GCALL2][7:1]) begin
         addr_hit = 1'b1;
      end
      if (regs_r[`LEDRP_REG_MODE_A][`LEDRP_MA_GCALL3_BIT] &&
          shift_r[7:1] == regs_r[`LEDRP_REG_GCALL3][7:1]) begin
         addr_hit = 1'b1;
      end
   end

   // Read view of the register at the pointer
   always_comb begin
      if (ptr == `LEDRP_REG_MODE_A) begin
         rd_data = {ctrl_r[`LEDRP_CTRL_OPT_MSB:`LEDRP_CTRL_OPT_LSB],
                    regs_r[`LEDRP_REG_MODE_A][4:0]};
      end else if (ptr == `LEDRP_REG_MODE_B) begin
         rd_data = regs_r[`LEDRP_REG_MODE_B] & `LEDRP_MODE_B_WR_MASK;
      end else if (ptr <= `LEDRP_PTR_LAST) begin
         rd_data = regs_r[ptr];
      end else begin
         rd_data = 8'h00;
      end
   end

   assign receiving = (state_r == ledrp_pkg::ST_ADDR) || (state_r == ledrp_pkg::ST_CTRL) ||
                      (state_r == ledrp_pkg::ST_WR);
   assign byte_end = scl_fall && (bit_cnt_r == 4'h8);
   assign addr_done = (state_r == ledrp_pkg::ST_ADDR) && byte_end;
   assign ctrl_done = (state_r == ledrp_pkg::ST_CTRL) && byte_end;
   assign ctrl_ok = (shift_r[`LEDRP_CTRL_PTR_MSB:0] <= `LEDRP_PTR_LAST);
   assign wr_done = (state_r == ledrp_pkg::ST_WR) && byte_end;
   assign rd_done = (state_r == ledrp_pkg::ST_RD) && scl_fall && (bit_cnt_r == 4'h7);
   assign rd_first = (state_r == ledrp_pkg::ST_ACK_ADDR) && scl_fall && read_r;
   assign rd_next = (state_r == ledrp_pkg::ST_ACK_RD) && scl_fall && !nack_r;
   assign rd_load = rd_first || rd_next;
   assign ack_end = scl_fall && ((state_r == ledrp_pkg::ST_ACK_ADDR) ||
                                 (state_r == ledrp_pkg::ST_ACK_CTRL) ||
                                 (state_r == ledrp_pkg::ST_ACK_WR) ||
                                 (state_r == ledrp_pkg::ST_ACK_RD));

   // Transfer sequencer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ledrp_pkg::ST_IDLE;
      end else if (bus_start) begin
         state_r <= ledrp_pkg::ST_ADDR;
      end else if (bus_stop) begin
         state_r <= ledrp_pkg::ST_IDLE;
      end else begin
         case (state_r)
            ledrp_pkg::ST_ADDR: begin
               if (addr_done) begin
                  state_r <= addr_hit ? ledrp_pkg::ST_ACK_ADDR : ledrp_pkg::ST_IDLE;
               end
            end
            ledrp_pkg::ST_ACK_ADDR: begin
               if (scl_fall) begin
                  state_r <= read_r ? ledrp_pkg::ST_RD : ledrp_pkg::ST_CTRL;
               end
            end
            ledrp_pkg::ST_CTRL: begin
               if (ctrl_done) begin
                  state_r <= ctrl_ok ? ledrp_pkg::ST_ACK_CTRL : ledrp_pkg::ST_IDLE;
               end
            end
            ledrp_pkg::ST_ACK_CTRL: begin
               if (scl_fall) begin
                  state_r <= ledrp_pkg::ST_WR;
               end
            end
            ledrp_pkg::ST_WR: begin
               if (wr_done) begin
                  state_r <= ledrp_pkg::ST_ACK_WR;
               end
            end
            ledrp_pkg::ST_ACK_WR: begin
               if (scl_fall) begin
                  state_r <= ledrp_pkg::ST_WR;
               end
            end
            ledrp_pkg::ST_RD: begin
               if (rd_done) begin
                  state_r <= ledrp_pkg::ST_ACK_RD;
               end
            end
            ledrp_pkg::ST_ACK_RD: begin
               if (scl_fall) begin
                  state_r <= nack_r ? ledrp_pkg::ST_IDLE : ledrp_pkg::ST_RD;
               end
            end
            default: begin
               state_r <= ledrp_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Received bits count on rising clock edges, sent bits on falling ones
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bit_cnt_r <= 4'h0;
      end else if (bus_start || ack_end || byte_end) begin
         bit_cnt_r <= 4'h0;
      end else if (receiving && scl_rise && bit_cnt_r != 4'h8) begin
         bit_cnt_r <= bit_cnt_r + 4'h1;
      end else if (state_r == ledrp_pkg::ST_RD && scl_fall && bit_cnt_r != 4'h7) begin
         bit_cnt_r <= bit_cnt_r + 4'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shift_r <= 8'h00;
      end else if (rd_load) begin
         shift_r <= rd_data;
      end else if (receiving && scl_rise && bit_cnt_r != 4'h8) begin
         shift_r <= {shift_r[6:0], sda_s};
      end else if (state_r == ledrp_pkg::ST_RD && scl_fall && bit_cnt_r != 4'h7) begin
         shift_r <= {shift_r[6:0], 1'b0};
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         read_r <= 1'b0;
      end else if (addr_done) begin
         read_r <= shift_r[0];
      end
   end

   // Master acknowledge is sampled while the clock is high
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         nack_r <= 1'b1;
      end else if (state_r == ledrp_pkg::ST_ACK_RD && scl_rise) begin
         nack_r <= sda_s;
      end
   end

   // Control byte: loaded whole, then only the pointer nibble moves
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= `LEDRP_CTRL_RESET;
      end else if (ctrl_done && ctrl_ok) begin
         ctrl_r <= shift_r;
      end else if (wr_done || rd_done) begin
         ctrl_r[`LEDRP_CTRL_PTR_MSB:0] <= ptr_nxt;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < `LEDRP_NUM_REGS; i++) begin
            regs_r[i] <= reg_reset(i);
         end
      end else if (wr_done && ptr <= `LEDRP_PTR_LAST) begin
         regs_r[ptr] <= (shift_r & wr_mask(ptr)) | (regs_r[ptr] & ~wr_mask(ptr));
      end
   end

   // Oscillator start-up delay after leaving low power
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wake_cnt_r <= '0;
      end else if (regs_r[`LEDRP_REG_MODE_A][`LEDRP_MA_LOW_POWER_BIT]) begin
         wake_cnt_r <= '0;
      end else if (wake_cnt_r != WAKE_LAST) begin
         wake_cnt_r <= wake_cnt_r + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         osc_ready_r <= 1'b0;
      end else begin
         osc_ready_r <= !regs_r[`LEDRP_REG_MODE_A][`LEDRP_MA_LOW_POWER_BIT] &&
                        (wake_cnt_r == WAKE_LAST);
      end
   end

   // Open drain: only ever pull low
   assign sda_o = 1'b0;
   always_comb begin
      case (state_r)
         ledrp_pkg::ST_ACK_ADDR: sda_oe = 1'b1;
         ledrp_pkg::ST_ACK_CTRL: sda_oe = 1'b1;
         ledrp_pkg::ST_ACK_WR: sda_oe = 1'b1;
         ledrp_pkg::ST_RD: sda_oe = ~shift_r[7];
         default: sda_oe = 1'b0;
      endcase
   end

   assign low_power_o = regs_r[`LEDRP_REG_MODE_A][`LEDRP_MA_LOW_POWER_BIT];
   // Ready drops in the same cycle that low power returns, not one later
   assign osc_ready_o = osc_ready_r & ~low_power_o;
   assign mode_config_b_o = regs_r[`LEDRP_REG_MODE_B] & `LEDRP_MODE_B_WR_MASK;
   assign led0_brightness_o = regs_r[`LEDRP_REG_LED0];
   assign led1_brightness_o = regs_r[`LEDRP_REG_LED1];
   assign led2_brightness_o = regs_r[`LEDRP_REG_LED2];
   assign led3_brightness_o = regs_r[`LEDRP_REG_LED3];
   assign group_duty_o = regs_r[`LEDRP_REG_GRP_DUTY];
   assign group_period_o = regs_r[`LEDRP_REG_GRP_PERIOD];
   assign led_output_select_o = regs_r[`LEDRP_REG_OUT_SEL];
   assign register_pointer_o = ptr;
   assign increment_option_o = ctrl_r[`LEDRP_CTRL_OPT_MSB:`LEDRP_CTRL_OPT_LSB];
endmodule

// File: bench/ledrp_top_properties.sv
module ledrp_top_properties #(
   parameter int WAKE_CYCLES = 50000
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic scl_i,
   input wire logic sda_oe,
   input wire logic low_power_o,
   input wire logic osc_ready_o,
   input wire logic [7:0] mode_config_b_o,
   input wire logic [7:0] led0_brightness_o,
   input wire logic [7:0] led1_brightness_o,
   input wire logic [7:0] led2_brightness_o,
   input wire logic [7:0] led3_brightness_o,
   input wire logic [7:0] group_duty_o,
   input wire logic [7:0] group_period_o,
   input wire logic [7:0] led_output_select_o,
   input wire logic [3:0] register_pointer_o,
   input wire logic [2:0] increment_option_o
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int OSC_AT = WAKE_CYCLES + 1;
   logic [15:0] lp_cnt_r;

   // Cycles spent out of low power, saturating
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) lp_cnt_r <= 16'h0000;
      else if (low_power_o) lp_cnt_r <= 16'h0000;
      else if (lp_cnt_r != 16'hFFFF) lp_cnt_r <= lp_cnt_r + 16'h0001;
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   osc_gated_a: assert property (low_power_o |-> !osc_ready_o)
      else $error("oscillator ready while in low power");
   osc_late_a: assert property (!low_power_o && lp_cnt_r >= OSC_AT |-> osc_ready_o)
      else $error("oscillator ready too late after wake");
   osc_early_a: assert property (osc_ready_o |-> lp_cnt_r >= OSC_AT)
      else $error("oscillator ready too early after wake");
   ptr_range_a: assert property (register_pointer_o <= 4'hC)
      else $error("register pointer beyond last register");
   modeb_resv_a: assert property (mode_config_b_o[7:6] == 2'b00)
      else $error("reserved mode bits set");
   data_edge_a: assert property ($changed(sda_oe) |-> !scl_i)
      else $error("data line changed while clock high");
   ptr_move_a: assert property ($changed(register_pointer_o) |-> !scl_i)
      else $error("pointer moved while clock high");
   opt_move_a: assert property ($changed(increment_option_o) |-> !scl_i)
      else $error("option moved while clock high");
   regs_move_a: assert property ($changed({led0_brightness_o, led1_brightness_o,
      led2_brightness_o, led3_brightness_o, group_duty_o, group_period_o,
      led_output_select_o, mode_config_b_o, low_power_o}) |-> !scl_i)
      else $error("register output moved while clock high");
endmodule

bind ledrp_top ledrp_top_properties #(.WAKE_CYCLES(WAKE_CYCLES)) u_props (
   .clk(clk), .rst_n(rst_n), .scl_i(scl_i), .sda_oe(sda_oe),
   .low_power_o(low_power_o), .osc_ready_o(osc_ready_o), .mode_config_b_o(mode_config_b_o),
   .led0_brightness_o(led0_brightness_o), .led1_brightness_o(led1_brightness_o),
   .led2_brightness_o(led2_brightness_o), .led3_brightness_o(led3_brightness_o),
   .group_duty_o(group_duty_o), .group_period_o(group_period_o),
   .led_output_select_o(led_output_select_o), .register_pointer_o(register_pointer_o),
   .increment_option_o(increment_option_o));

// File: bench/ledrp_i2c_master.sv
module ledrp_i2c_master (
   input wire logic clk,
   input wire logic sda_in,
   output logic scl,
   output logic sda_low
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Data moves mid way through clock low so setup and hold both exceed the synchroniser lag
   task automatic put_bit(input logic b, output logic seen);
      tick(4);
      sda_low <= ~b;
      tick(4);
      scl <= 1'b1;
      tick(4);
      #1 seen = sda_in;
      tick(4);
      scl <= 1'b0;
   endtask

   task automatic start_c;
      tick(4);
      sda_low <= 1'b0;
      tick(4);
      scl <= 1'b1;
      tick(8);
      sda_low <= 1'b1;
      tick(8);
      scl <= 1'b0;
   endtask

   task automatic stop_c;
      tick(4);
      sda_low <= 1'b1;
      tick(4);
      scl <= 1'b1;
      tick(8);
      sda_low <= 1'b0;
      tick(8);
   endtask

   // Ninth bit b9 high releases the line, which is a refusal when reading
   task automatic xfer(input logic [7:0] d, input logic b9, output logic [7:0] q,
                       output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         put_bit(d[i], s);
         q[i] = s;
      end
      put_bit(b9, s);
      ack = ~s;
   endtask
endmodule

// File: bench/led_driver_register_pointer_tb.sv
module led_driver_register_pointer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [6:0] SLV = 7'h2A; // Arbitrary bus address
   localparam int WAKE = 20;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic scl, m_low, sda_oe, sda_out, low_power, osc_ready;
   wire sda;
   logic [7:0] mode_b, led0, led1, led2, led3, duty, period, outsel;
   logic [3:0] ptr;
   logic [2:0] opt;
   logic [7:0] shadow [13] = '{8'h11, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00,
                              8'h00, 8'hE2, 8'hE4, 8'hE8, 8'hE0};
   logic [3:0] ptr_m = 4'h0;
   logic [2:0] opt_m = 3'h4;
   logic wake = 1'b0;
   logic [2:0] opts [5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
   int err_total = 0;
   int n_tests = 0;
   int seed = 54;

   // Open drain line with pull-up
   assign sda = ~m_low & (sda_oe ? sda_out : 1'b1);
   always #5 clk = ~clk;

   ledrp_top #(.SLAVE_ADDR(SLV), .WAKE_CYCLES(WAKE)) u_dut (
      .clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_out), .sda_oe(sda_oe),
      .low_power_o(low_power), .osc_ready_o(osc_ready), .mode_config_b_o(mode_b),
      .led0_brightness_o(led0), .led1_brightness_o(led1), .led2_brightness_o(led2),
      .led3_brightness_o(led3), .group_duty_o(duty), .group_period_o(period),
      .led_output_select_o(outsel), .register_pointer_o(ptr), .increment_option_o(opt));

   ledrp_i2c_master u_master (.clk(clk), .sda_in(sda), .scl(scl), .sda_low(m_low));

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("unexpected %s: expected %h seen %h", what, exp, got);
         err_total++;
      end
   endtask

   function automatic logic [3:0] step(input logic [3:0] p, input logic [2:0] o);
      if (!o[2]) return p;
      if (o == 3'h5 && p == 4'h5) return 4'h2;
      if (o == 3'h6 && p == 4'h7) return 4'h6;
      if (o == 3'h7 && p == 4'h7) return 4'h2;
      return (p >= 4'hC) ? 4'h0 : p + 4'h1;
   endfunction

   function automatic logic [7:0] rd_exp(input logic [3:0] p);
      return (p == 4'h0) ? {opt_m, shadow[0][4:0]} : shadow[p];
   endfunction

   function automatic logic addr_ack(input logic [6:0] a);
      return a == SLV || (a == shadow[12][7:1] && shadow[0][0]) ||
         (a == shadow[9][7:1] && shadow[0][3]) || (a == shadow[10][7:1] && shadow[0][2]) ||
         (a == shadow[11][7:1] && shadow[0][1]);
   endfunction

   task automatic wr_seq(input logic [7:0] c, input int n, input logic c_ack);
      logic [7:0] q, d;
      logic a;
      u_master.start_c();
      u_master.xfer({SLV, 1'b0}, 1'b1, q, a);
      check("address ack", 8'h01, a);
      u_master.xfer(c, 1'b1, q, a);
      check("control ack", c_ack, a);
      if (c_ack) begin
         ptr_m = c[3:0];
         opt_m = c[7:5];
      end
      for (int i = 0; i < n; i++) begin
         d = 8'($random(seed));
         // Keep the device awake only when the scenario asks for it
         if (ptr_m == 4'h0) d[4] = ~wake;
         u_master.xfer(d, 1'b1, q, a);
         check("data ack", 8'h01, a);
         if (ptr_m == 4'h0) shadow[0][4:0] = d[4:0];
         else if (ptr_m == 4'h1) shadow[1] = {2'b00, d[5:0]};
         else shadow[ptr_m] = d;
         ptr_m = step(ptr_m, opt_m);
      end
      u_master.stop_c();
   endtask

   task automatic rd_seq(input int n);
      logic [7:0] q;
      logic a;
      u_master.start_c();
      u_master.xfer({SLV, 1'b1}, 1'b1, q, a);
      check("address ack", 8'h01, a);
      for (int i = 0; i < n; i++) begin
         u_master.xfer(8'hFF, i == n - 1, q, a);
         check("read data", rd_exp(ptr_m), q);
         ptr_m = step(ptr_m, opt_m);
      end
      u_master.stop_c();
   endtask

   task automatic probe_all;
      logic [7:0] q;
      logic a;
      logic [6:0] list [6];
      list = '{SLV, shadow[9][7:1], shadow[10][7:1], shadow[11][7:1], shadow[12][7:1], 7'h15};
      foreach (list[i]) begin
         u_master.start_c();
         u_master.xfer({list[i], 1'b0}, 1'b1, q, a);
         check("call ack", addr_ack(list[i]), a);
         u_master.stop_c();
      end
   endtask

   task automatic out_check;
      logic [7:0] o [7];
      o = '{led0, led1, led2, led3, duty, period, outsel};
      check("pointer", ptr_m, ptr);
      check("option", opt_m, opt);
      check("low power", shadow[0][4], low_power);
      check("mode b", shadow[1], mode_b);
      foreach (o[i]) check("register output", shadow[i + 2], o[i]);
   endtask

   task automatic tally_and_finish;
      $display("counts: %0d checks, %0d mismatches", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   initial begin
      repeat (90000) @(posedge clk);
      err_total++;
      $display("unexpected run length: expected done seen hang");
      tally_and_finish();
   end

   initial begin
      logic [7:0] c;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge clk);
      check("osc ready", 8'h00, osc_ready);
      check("data drive", 8'h00, sda_oe);
      out_check();
      rd_seq(14);
      probe_all();
      $display("test reset_values done");
      wr_seq(8'hE8, 0, 1'b1);
      rd_seq(24);
      for (int p = 13; p < 16; p++) wr_seq({3'h4, 1'b0, 4'(p)}, 0, 1'b0);
      out_check();
      $display("test pointer_corners done");
      repeat (14) begin
         c = {opts[$unsigned($random(seed)) % 5], 1'b0, 4'($unsigned($random(seed)) % 13)};
         wr_seq(c, 1 + $unsigned($random(seed)) % 8, 1'b1);
         rd_seq(1 + $unsigned($random(seed)) % 5);
         out_check();
         probe_all();
      end
      $display("test random_bursts done");
      wake = 1'b1;
      wr_seq(8'h00, 1, 1'b1);
      out_check();
      for (int i = 0; i < WAKE + 10 && osc_ready !== 1'b1; i++) @(posedge clk);
      check("osc ready", 8'h01, osc_ready);
      wr_seq(8'h82, 4, 1'b1);
      out_check();
      // Back into low power: ready must drop with it
      wake = 1'b0;
      wr_seq(8'h00, 1, 1'b1);
      check("osc ready", 8'h00, osc_ready);
      out_check();
      $display("test wake done");
      tally_and_finish();
   end
endmodule
